// ==== shared/pwm_defines.svh ====
// Register offsets, field positions, reset values and timing counts of the bridge PWM.
// Assumes a Wishbone word bus: register index times four is the byte address.
`ifndef PWM_DEFINES_SVH
`define PWM_DEFINES_SVH

// Register indices as printed
`define IDX_INTERRUPT_CONTROL 8'h0B
`define IDX_PERIPHERAL_FLAGS 8'h0C
`define IDX_PERIOD_TIMER_COUNT 8'h11
`define IDX_PERIOD_TIMER_CONTROL 8'h12
`define IDX_DUTY_WRITE_LOW 8'h15
`define IDX_PWM_MODE_CONTROL 8'h17
`define IDX_PORT_B_DIRECTION 8'h86
`define IDX_PERIPHERAL_ENABLES 8'h8C
`define IDX_PERIOD_LIMIT 8'h92
`define IDX_DEAD_BAND_DELAY 8'h97
`define IDX_DUTY_SHADOW 8'h16

// Reset values
`define RST_PERIOD_LIMIT 8'hFF
`define RST_PORT_B_DIRECTION 8'hFF
`define RST_ZERO 8'h00

// Field positions
`define FLD_PERIOD_MATCH 1
`define FLD_TIMER_RUN 2
`define FLD_DUTY_LOW_HI 5
`define FLD_DUTY_LOW_LO 4
`define FLD_BRIDGE_HI 7
`define FLD_BRIDGE_LO 6
`define FLD_POSTSCALE_HI 6
`define FLD_POSTSCALE_LO 3

// Bridge pin positions on port B (a on the main pin)
`define PIN_A 3
`define PIN_B 5
`define PIN_C 6
`define PIN_D 7

// One instruction cycle is four oscillator periods
`define OSC_PER_INSTR 4
`define INSTR_CYCLES(c) ((c) * `OSC_PER_INSTR)

`endif

// ==== shared/pwm_pkg.sv ====
// Types shared by the bridge PWM design.
// Assumes the defines header supplies numeric constants.
package pwm_pkg;
  // Output arrangement selection
  typedef enum logic [1:0] {
    BRIDGE_SINGLE = 2'h0,
    BRIDGE_FWD = 2'h1,
    BRIDGE_HALF = 2'h2,
    BRIDGE_REV = 2'h3
  } bridge_mode_e;
  // Dead band sequencer, gray from IDLE through WAIT to DRIVE; DRIVE back to IDLE flips both bits
  typedef enum logic [1:0] {
    DB_IDLE = 2'h0,
    DB_WAIT = 2'h1,
    DB_DRIVE = 2'h3
  } dead_band_e;
endpackage

// ==== logic/bridge_pwm.sv ====
// Bridge PWM with period timer, double-buffered 10-bit duty and dead band.
// Assumes a 20 MHz clk_i as oscillator, classic Wishbone master, sync reset.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_defines.svh"

module bridge_pwm (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Bridge pins: level and enable, enable low while driving
  output logic bridge_out_a_o,
  output logic bridge_out_b_o,
  output logic bridge_out_c_o,
  output logic bridge_out_d_o,
  output logic [3:0] bridge_oe_n_o
);

  // Software registers
  logic [7:0] interrupt_control_reg;
  logic [7:0] peripheral_flags_reg;
  logic [7:0] period_timer_reg;
  logic [7:0] period_timer_control_reg;
  logic [7:0] duty_write_reg;
  logic [7:0] pwm_mode_control_reg;
  logic [7:0] port_b_direction_reg;
  logic [7:0] peripheral_enables_reg;
  logic [7:0] period_limit_reg;
  logic [7:0] dead_band_delay_reg;
  // Internal timing state
  logic [9:0] duty_shadow_reg;
  logic [3:0] prescale_cnt_reg;
  logic [3:0] postscale_cnt_reg;
  logic [1:0] osc_cnt_reg;
  logic pwm_level_reg;
  logic [9:0] db_cnt_reg;
  pwm_pkg::dead_band_e db_state_reg;
  logic db_lead_reg;

  // Bus decode
  logic bus_req;
  logic bus_wr;
  logic [7:0] bus_idx;
  logic [7:0] wr_byte;
  assign bus_req = cyc_i && stb_i && !ack_o;
  assign bus_wr = bus_req && we_i && sel_i[0];
  assign bus_idx = adr_i[9:2];
  assign wr_byte = dat_i[7:0];

  // Write strobe for one register index
  function automatic logic wr_hit(input logic [7:0] idx);
    wr_hit = bus_wr && (bus_idx == idx);
  endfunction

  // Prescale factor from select field: 1, 4, 16, 16
  function automatic logic [3:0] prescale_max(input logic [1:0] sel);
    unique case (sel)
      2'h0: prescale_max = 4'h0;
      2'h1: prescale_max = 4'h3;
      default: prescale_max = 4'hF;
    endcase
  endfunction

  // Instruction cycle tick: one every four oscillator periods
  logic instr_tick;
  assign instr_tick = (osc_cnt_reg == 2'(`OSC_PER_INSTR - 1));
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      osc_cnt_reg <= 2'h0;
    else
      osc_cnt_reg <= osc_cnt_reg + 2'h1;
  end

  // Timer increment enable after prescaler
  logic timer_run;
  logic timer_inc;
  logic period_match;
  logic rollover;
  assign timer_run = period_timer_control_reg[`FLD_TIMER_RUN];
  assign timer_inc = timer_run && instr_tick
    && (prescale_cnt_reg == prescale_max(period_timer_control_reg[1:0]));
  assign period_match = (period_timer_reg == period_limit_reg);
  assign rollover = timer_inc && period_match;

  // Prescaler counts instruction cycles only while running
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prescale_cnt_reg <= 4'h0;
    else if (wr_hit(`IDX_PERIOD_TIMER_COUNT) || wr_hit(`IDX_PERIOD_TIMER_CONTROL))
      prescale_cnt_reg <= 4'h0; // Timer writes restart the prescaler
    else if (timer_inc)
      prescale_cnt_reg <= 4'h0;
    else if (timer_run && instr_tick)
      prescale_cnt_reg <= prescale_cnt_reg + 4'h1;
  end

  // Period timer: clears on the increment after matching the limit
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      period_timer_reg <= `RST_ZERO;
    else if (wr_hit(`IDX_PERIOD_TIMER_COUNT))
      period_timer_reg <= wr_byte;
    else if (rollover)
      period_timer_reg <= 8'h00;
    else if (timer_inc)
      period_timer_reg <= period_timer_reg + 8'h01;
  end

  // Postscaler divides match events for the flag only
  logic post_done;
  assign post_done = (postscale_cnt_reg
    == period_timer_control_reg[`FLD_POSTSCALE_HI:`FLD_POSTSCALE_LO]);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      postscale_cnt_reg <= 4'h0;
    else if (rollover && post_done)
      postscale_cnt_reg <= 4'h0;
    else if (rollover)
      postscale_cnt_reg <= postscale_cnt_reg + 4'h1;
  end

  // Duty reload into shadow at rollover; never touched directly by software
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      duty_shadow_reg <= 10'h000;
    else if (rollover)
      duty_shadow_reg <= {duty_write_reg,
        pwm_mode_control_reg[`FLD_DUTY_LOW_HI:`FLD_DUTY_LOW_LO]};
  end

  // Extended timer: one count per duty step, so duty is in prescaled oscillator periods
  logic [9:0] timer_ext;
  assign timer_ext = {period_timer_reg, (period_timer_control_reg[1:0] == 2'h0) ? osc_cnt_reg
    : (period_timer_control_reg[1] ? prescale_cnt_reg[3:2] : prescale_cnt_reg[1:0])};

  // Period start flag: set at rollover unless the new duty is zero
  logic [9:0] next_duty;
  assign next_duty = {duty_write_reg, pwm_mode_control_reg[5:4]};
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pwm_level_reg <= 1'b0;
    else if (rollover)
      pwm_level_reg <= (next_duty != 10'h000);
  end

  // Main level falls in the very cycle the extended timer reaches duty
  logic pwm_level;
  assign pwm_level = pwm_level_reg && (timer_ext < duty_shadow_reg);

  // Dead band sequencer for half bridge: leading edge delayed
  logic half_mode;
  assign half_mode = (pwm_mode_control_reg[`FLD_BRIDGE_HI:`FLD_BRIDGE_LO]
    == pwm_pkg::BRIDGE_HALF);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      db_state_reg <= pwm_pkg::DB_IDLE;
      db_cnt_reg <= 10'h000;
      db_lead_reg <= 1'b0;
    end
    else
    begin
      unique case (db_state_reg)
        pwm_pkg::DB_IDLE:
        begin
          // In half mode with a nonzero delay, any edge of the PWM level starts a delay
          if (pwm_level != db_lead_reg)
          begin
            if (!half_mode || dead_band_delay_reg == 8'h00)
              db_lead_reg <= pwm_level; // zero means no delay
            else
            begin
              db_cnt_reg <= 10'(`INSTR_CYCLES(dead_band_delay_reg)) - 10'h001;
              db_state_reg <= pwm_pkg::DB_WAIT;
            end
          end
        end
        pwm_pkg::DB_WAIT:
        begin
          // Both sides off while counting
          if (db_cnt_reg == 10'h000)
            db_state_reg <= pwm_pkg::DB_DRIVE;
          else
            db_cnt_reg <= db_cnt_reg - 10'h001;
        end
        pwm_pkg::DB_DRIVE:
        begin
          db_lead_reg <= pwm_level;
          db_state_reg <= pwm_pkg::DB_IDLE;
        end
        default:
          db_state_reg <= pwm_pkg::DB_IDLE;
      endcase
    end
  end

  // Active-level outputs before polarity, per arrangement
  logic [3:0] raw_out;
  logic db_gap;
  assign db_gap = (db_state_reg != pwm_pkg::DB_IDLE);
  always_comb
  begin
    raw_out = 4'h0;
    unique case (pwm_pkg::bridge_mode_e'(pwm_mode_control_reg[7:6]))
      pwm_pkg::BRIDGE_SINGLE: raw_out = {3'h0, pwm_level};
      pwm_pkg::BRIDGE_HALF: raw_out = db_gap ? 4'h0 : {2'h0, ~db_lead_reg, db_lead_reg};
      pwm_pkg::BRIDGE_FWD: raw_out = {pwm_level, 2'h0, 1'b1};
      pwm_pkg::BRIDGE_REV: raw_out = {1'b0, 1'b1, pwm_level, 1'b0};
    endcase
  end

  // Polarity: mode bit 1 sets a/c low-active, bit 0 sets b/d low-active
  logic [3:0] pol_out;
  assign pol_out = raw_out ^ {pwm_mode_control_reg[0], pwm_mode_control_reg[1],
    pwm_mode_control_reg[0], pwm_mode_control_reg[1]};

  // Output latches update every cycle, so one period fully initialises them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bridge_out_a_o <= 1'b0;
      bridge_out_b_o <= 1'b0;
      bridge_out_c_o <= 1'b0;
      bridge_out_d_o <= 1'b0;
      bridge_oe_n_o <= 4'hF;
    end
    else
    begin
      bridge_out_a_o <= pol_out[0];
      bridge_out_b_o <= pol_out[1];
      bridge_out_c_o <= pol_out[2];
      bridge_out_d_o <= pol_out[3];
      bridge_oe_n_o <= {port_b_direction_reg[`PIN_D], port_b_direction_reg[`PIN_C],
        port_b_direction_reg[`PIN_B], port_b_direction_reg[`PIN_A]};
    end
  end

  // Match flag: hardware set wins over a software clear
  logic flag_set;
  assign flag_set = rollover && post_done;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      peripheral_flags_reg <= `RST_ZERO;
    else
    begin
      if (wr_hit(`IDX_PERIPHERAL_FLAGS))
        peripheral_flags_reg <= wr_byte & 8'h4F; // Unimplemented bits stay zero
      if (flag_set)
        peripheral_flags_reg[`FLD_PERIOD_MATCH] <= 1'b1;
    end
  end

  // Plain software registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      interrupt_control_reg <= `RST_ZERO;
      period_timer_control_reg <= `RST_ZERO;
      duty_write_reg <= `RST_ZERO;
      pwm_mode_control_reg <= `RST_ZERO;
      port_b_direction_reg <= `RST_PORT_B_DIRECTION;
      peripheral_enables_reg <= `RST_ZERO;
      period_limit_reg <= `RST_PERIOD_LIMIT;
      dead_band_delay_reg <= `RST_ZERO;
    end
    else
    begin
      if (wr_hit(`IDX_INTERRUPT_CONTROL))
        interrupt_control_reg <= wr_byte;
      if (wr_hit(`IDX_PERIOD_TIMER_CONTROL))
        period_timer_control_reg <= wr_byte & 8'h7F;
      if (wr_hit(`IDX_DUTY_WRITE_LOW))
        duty_write_reg <= wr_byte;
      if (wr_hit(`IDX_PWM_MODE_CONTROL))
        pwm_mode_control_reg <= wr_byte;
      if (wr_hit(`IDX_PORT_B_DIRECTION))
        port_b_direction_reg <= wr_byte;
      if (wr_hit(`IDX_PERIPHERAL_ENABLES))
        peripheral_enables_reg <= wr_byte & 8'h4F;
      if (wr_hit(`IDX_PERIOD_LIMIT))
        period_limit_reg <= wr_byte;
      if (wr_hit(`IDX_DEAD_BAND_DELAY))
        dead_band_delay_reg <= wr_byte;
    end
  end

  // Read mux; unmapped indices read zero
  logic [7:0] rd_byte;
  always_comb
  begin
    unique case (bus_idx)
      `IDX_INTERRUPT_CONTROL: rd_byte = interrupt_control_reg;
      `IDX_PERIPHERAL_FLAGS: rd_byte = peripheral_flags_reg;
      `IDX_PERIOD_TIMER_COUNT: rd_byte = period_timer_reg;
      `IDX_PERIOD_TIMER_CONTROL: rd_byte = period_timer_control_reg;
      `IDX_DUTY_WRITE_LOW: rd_byte = duty_write_reg;
      `IDX_DUTY_SHADOW: rd_byte = duty_shadow_reg[9:2];
      `IDX_PWM_MODE_CONTROL: rd_byte = pwm_mode_control_reg;
      `IDX_PORT_B_DIRECTION: rd_byte = port_b_direction_reg;
      `IDX_PERIPHERAL_ENABLES: rd_byte = peripheral_enables_reg;
      `IDX_PERIOD_LIMIT: rd_byte = period_limit_reg;
      `IDX_DEAD_BAND_DELAY: rd_byte = dead_band_delay_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  // Single-wait ack; every address is answered so the bus never hangs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= bus_req;
      if (bus_req && !we_i)
        dat_o <= {24'h000000, rd_byte};
    end
  end

endmodule
`default_nettype wire

// ==== test/power_switch.sv ====
// Stand-in for the external power switches on the four bridge pins.
// Assumes pull-downs keep a released pin, and so its switch, off.
`timescale 1ns/1ps
`default_nettype none
module power_switch (
  // Pin levels and active-low enables
  input wire logic [3:0] lvl_i,
  input wire logic [3:0] oe_n_i,
  // Gate level each switch sees
  output logic [3:0] gate_o
);
  // Released pin falls to its pull-down, never keeps a stale level
  assign gate_o = lvl_i & ~oe_n_i;
endmodule
`default_nettype wire

// ==== test/bridge_pwm_assertions.sv ====
// Port-level checker for the bridge PWM: bus handshake and pin release.
// Assumes it is bound to the top module with every port by name.
`timescale 1ns/1ps
`default_nettype none
module bridge_pwm_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Bridge pins
  input wire logic bridge_out_a_o,
  input wire logic bridge_out_b_o,
  input wire logic bridge_out_c_o,
  input wire logic bridge_out_d_o,
  input wire logic [3:0] bridge_oe_n_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Request taken this edge
  wire logic req = cyc_i && stb_i && !ack_o;
  // Write to the direction register
  wire logic wr_dir = req && we_i && sel_i[0] && adr_i[9:2] == 8'h86;
  // Register holes read back as zero
  wire logic mapped = adr_i[9:2] inside {8'h0B, 8'h0C, 8'h11, 8'h12, 8'h15, 8'h16,
    8'h17, 8'h86, 8'h8C, 8'h92, 8'h97};
  // Enables expected from the last direction write
  logic [3:0] exp_oe;
  always_ff @(posedge clk_i)
    if (wr_dir)
      exp_oe <= {dat_i[7], dat_i[6], dat_i[5], dat_i[3]};
  ack_latency_a: assert property (req |=> ack_o) else $error("ack late");
  ack_single_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
  ack_cause_a: assert property (ack_o |-> $past(req)) else $error("ack without request");
  read_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper bits set");
  hole_read_a: assert property (req && !we_i && !mapped |=> dat_o == 32'h0)
    else $error("hole read nonzero");
  reset_quiet_a: assert property ($fell(rst_i) |-> bridge_oe_n_o == 4'hF && !ack_o)
    else $error("pins driven after reset");
  pin_release_a: assert property (wr_dir |-> ##2 bridge_oe_n_o == exp_oe)
    else $error("enables do not follow direction");
  oe_hold_a: assert property ($changed(bridge_oe_n_o) |-> $past(wr_dir) || $past(wr_dir, 2))
    else $error("enables moved on their own");
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the bridge PWM: register mirror and pin timing.
// Assumes a 50 ns clock, classic Wishbone and pulled-down bridge pins.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // Bus and pin signals
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [9:0] adr_i = 10'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, pa, pb, pc, pd;
  logic [3:0] oe_n, gate;
  // Register mirror, tallies and tables
  logic [7:0] mdl [logic [7:0]];
  int errors = 0, cmp_count = 0, per, hi, ha, hc, hab, hnb, hd;
  logic [7:0] q, r;
  logic [7:0] ix [11] = '{8'h0B, 8'h0C, 8'h11, 8'h12, 8'h15, 8'h16, 8'h17, 8'h86, 8'h8C,
    8'h92, 8'h97};
  logic [7:0] rw [6] = '{8'h92, 8'h97, 8'h8C, 8'h15, 8'h17, 8'h11};
  logic [7:0] mc [4] = '{8'h60, 8'hE0, 8'h62, 8'hA0};
  int f [4] = '{1, 4, 16, 16};
  always #25 clk_i = ~clk_i;
  bridge_pwm dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .bridge_out_a_o(pa), .bridge_out_b_o(pb), .bridge_out_c_o(pc), .bridge_out_d_o(pd),
    .bridge_oe_n_o(oe_n));
  power_switch sw_u (.lvl_i({pd, pc, pb, pa}), .oe_n_i(oe_n), .gate_o(gate));
  // Verdict and end of run
  task automatic close_out();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask
  // One classic cycle; held until ack, then one idle cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic s);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {a, 2'b00};
    sel_i <= {3'b000, s};
    dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        errors++;
        close_out();
      end
      @(posedge clk_i);
    end
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b1);
    // Unimplemented flag, enable and control bits read back as zero
    if (mdl.exists(a))
      mdl[a] = (a == 8'h8C || a == 8'h0C) ? (d & 8'h4F) : ((a == 8'h12) ? (d & 8'h7F) : d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 8'h00, 1'b0);
    chk(q, mdl.exists(a) ? mdl[a] : 8'h00);
  endtask
  // Mirror back to its reset state
  task automatic mreset();
    foreach (ix[i])
      mdl[ix[i]] = 8'h00;
    mdl[8'h92] = 8'hFF;
    mdl[8'h86] = 8'hFF;
  endtask
  // Period and high time of the main gate, rising edge to rising edge
  task automatic meas();
    int t0, t1;
    logic prev;
    t0 = -1;
    t1 = -1;
    hi = 0;
    prev = 1'b1;
    for (int k = 0; k < 1200 && t1 < 0; k++)
    begin
      @(posedge clk_i);
      if (t0 >= 0 && gate[0] === 1'b1)
        hi++;
      if (!prev && gate[0] === 1'b1)
        if (t0 < 0)
          t0 = k;
        else
          t1 = k;
      prev = gate[0];
    end
    per = t1 - t0;
  endtask
  // High counts over 64 cycles once outputs settle
  task automatic cnt();
    ha = 0;
    hc = 0;
    hab = 0;
    hnb = 0;
    hd = 0;
    repeat (36) @(posedge clk_i);
    repeat (64)
    begin
      @(posedge clk_i);
      ha += (gate[0] === 1'b1);
      hc += (gate[2] === 1'b1);
      hab += (gate[0] === 1'b1 && gate[1] === 1'b1);
      hnb += (gate[0] === 1'b0 && gate[1] === 1'b0);
      hd += (gate[3] === 1'b1);
    end
  endtask
  initial
  begin
    void'($urandom(32'hCA1087DD));
    mreset();
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(oe_n, 4'hF);
    foreach (ix[i])
      rd(ix[i]);
    $display("test reset done");
    // Random round trips, a masked write and a hole
    foreach (rw[i])
    begin
      wr(rw[i], 8'($urandom));
      rd(rw[i]);
    end
    r = 8'($urandom);
    wr(8'h86, r);
    chk(oe_n, {r[7], r[6], r[5], r[3]});
    bus(1'b1, 8'h97, 8'h5A, 1'b0);
    rd(8'h97);
    wr(8'h40, 8'hA5);
    rd(8'h40);
    $display("test registers done");
    // Period per prescale, duty 6 of 16, pins held off until the flag
    wr(8'h86, 8'hFF);
    wr(8'h11, 8'h00);
    wr(8'h8C, 8'h00);
    wr(8'h92, 8'h03);
    wr(8'h15, 8'h01);
    wr(8'h17, 8'h20);
    for (int ps = 0; ps < 4; ps++)
    begin
      wr(8'h0C, 8'h00);
      wr(8'h12, {1'b0, 4'($urandom), 1'b1, 2'(ps)});
      q = 8'h00;
      for (int n = 0; n < 2000 && q[1] !== 1'b1; n++)
        bus(1'b0, 8'h0C, 8'h00, 1'b0);
      chk(q[1], 1'b1);
      wr(8'h86, 8'h00);
      meas();
      chk(per, 16 * f[ps]);
      if (ps == 0)
        chk(hi, 6);
      wr(8'h12, 8'h00);
      wr(8'h86, 8'hFF);
    end
    mdl[8'h0C] = 8'h02;
    mdl[8'h16] = 8'h01;
    rd(8'h0C);
    rd(8'h16);
    bus(1'b0, 8'h11, 8'h00, 1'b0);
    r = q;
    repeat (20) @(posedge clk_i);
    bus(1'b0, 8'h11, 8'h00, 1'b0);
    chk(q, r);
    wr(8'h0C, 8'h00);
    rd(8'h0C);
    $display("test period done");
    // Zero duty, then the forward, reverse and half-bridge arrangements with a dead band of one
    wr(8'h15, 8'h00);
    wr(8'h17, 8'h00);
    wr(8'h86, 8'h00);
    wr(8'h12, 8'h04);
    cnt();
    chk(ha, 0);
    wr(8'h15, 8'h01);
    wr(8'h97, 8'h01);
    foreach (mc[i])
    begin
      wr(8'h17, mc[i]);
      cnt();
      case (i)
        0:
        begin
          chk(ha, 64);
          chk(hd, 24);
        end
        1: chk(hc, 64);
        2: chk(ha, 0);
        default:
        begin
          chk(hab, 0);
          chk(hnb, 40);
        end
      endcase
    end
    $display("test modes done");
    // Reset in mid-run releases the pins again
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(oe_n, 4'hF);
    mreset();
    rd(8'h92);
    $display("test second reset done");
    close_out();
  end
endmodule
bind bridge_pwm bridge_pwm_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .bridge_out_a_o(bridge_out_a_o), .bridge_out_b_o(bridge_out_b_o),
  .bridge_out_c_o(bridge_out_c_o), .bridge_out_d_o(bridge_out_d_o),
  .bridge_oe_n_o(bridge_oe_n_o));
`default_nettype wire
